// [rtl/split_timer_defs.svh]
`ifndef SPLIT_TIMER_DEFS_SVH
`define SPLIT_TIMER_DEFS_SVH

// ****************************************************
// Timing
// ****************************************************
`define CLK_PERIOD_NS 10
`define DIV12_CYCLES 12
`define TICK_PERIOD_NS 5330
`define PULSE_PERIOD_US 100
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define PULSE_CYCLES (`PULSE_PERIOD_US * 1000 / `CLK_PERIOD_NS)

// ****************************************************
// Register addresses and offsets
// ****************************************************
`define ADDR_CLKSEL 8'hC9
`define BASE_UNIT_A 8'hC8
`define BASE_UNIT_B 8'hD0
`define OFS_CTRL 8'h00
`define OFS_RLD_L 8'h02
`define OFS_RLD_H 8'h03
`define OFS_CNT_L 8'h04
`define OFS_CNT_H 8'h05

// ****************************************************
// Reset values
// ****************************************************
`define CLKSEL_RESET 8'h00
`define CTRL_RESET 8'h00
`define BYTE_RESET 8'h00

// ****************************************************
// Control bit positions
// ****************************************************
`define CB_HFLAG 7
`define CB_LFLAG 6
`define CB_LIRQ_EN 5
`define CB_SPLIT 4
`define CB_HCAP 3
`define CB_LCAP 2
`define CB_HRUN 1
`define CB_LRUN 0

// ****************************************************
// Write strobe indices and clock source codes
// ****************************************************
`define WS_CTRL 0
`define WS_RLD_L 1
`define WS_RLD_H 2
`define WS_CNT_L 3
`define WS_CNT_H 4
`define SRC_SYS 2'h0
`define SRC_DIV12 2'h1
`define SRC_TICK 2'h2
`define SRC_PULSE 2'h3

`endif

// [rtl/split_timer_pkg.sv]
package split_timer_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [1:0] clk_field_t;
  // Readback view: ctrl, reload low, reload high, count low, count high
  typedef logic [4:0][7:0] reg_view_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] rld;
    logic irq;
  } unit_state_s;

  typedef struct packed {
    logic [3:0] div;
    logic [9:0] tick;
    logic [13:0] pulse;
    logic en_div12;
    logic en_tick;
    logic en_pulse;
  } gen_state_s;

  typedef struct packed {
    logic [7:0] clksel;
    logic [7:0] rdata;
  } top_state_s;

endpackage

// [rtl/count_src_if.sv]
`timescale 1ns/100ps

interface count_src_if;
  logic div12;
  logic tick;
  logic pulse;
  modport src (output div12, output tick, output pulse);
  modport dst (input div12, input tick, input pulse);
endinterface

// [rtl/count_source_gen.sv]
`timescale 1ns/100ps
`include "split_timer_defs.svh"

module count_source_gen #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  count_src_if.src src // Count enables
);
  import split_timer_pkg::*;

  gen_state_s s, n;

  if (TICK_CYCLES < 2 || TICK_CYCLES > 1023)
    $error("TICK_CYCLES out of range");
  if (PULSE_CYCLES < 2 || PULSE_CYCLES > 16383)
    $error("PULSE_CYCLES out of range");

  // ****************************************************
  // Enable dividers
  // ****************************************************
  // Sources are enables, never clocks, so no crossing is needed
  always_comb
  begin
    n = s;
    n.en_div12 = (s.div == 4'(`DIV12_CYCLES - 1));
    n.div = n.en_div12 ? 4'h0 : 4'(s.div + 4'h1);
    n.en_tick = (s.tick == 10'(TICK_CYCLES - 1));
    n.tick = n.en_tick ? 10'h000 : 10'(s.tick + 10'h001);
    n.en_pulse = (s.pulse == 14'(PULSE_CYCLES - 1));
    n.pulse = n.en_pulse ? 14'h0000 : 14'(s.pulse + 14'h0001);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  assign src.div12 = s.en_div12;
  assign src.tick = s.en_tick;
  assign src.pulse = s.en_pulse;

  property p_div12_period;
    @(posedge clk_sys) disable iff (!rst_n)
    s.en_div12 |-> ##12 s.en_div12;
  endproperty
  a_div12_period: assert property (p_div12_period)
    else $error("div12 enable period wrong");

endmodule // count_source_gen

// [rtl/dual_split_timer_capture.sv]
// Behaviour
// - Wide, low-capture off: one 16-bit up-counter with auto reload.
// - Wide timer rollover FFFF loads 16-bit reload and sets high flag.
// - Wide timer: low byte FF to 00 sets low flag.
// - Wide capture: free-running 16-bit up-counter wrapping to zero.
// - Wide capture event copies both count bytes to reload, sets high flag.
// - Wide capture: 16-bit wrap sets low flag as overflow marker.
// - Wide capture still works while low run is cleared.
// - Unit A captures on event zero, unit B on event one.
// - Capture never consumes the event; its own interrupt stays usable.
// - Split: two independent 8-bit halves sharing event and irq.
// - Split timer half reloads on FF rollover and sets its flag.
// - Split capture half wraps freely and captures its byte.
// - Both halves capturing: one event sets both flags together.
// - Split capture half captures even with its run cleared.
// - Each split half picks timer or capture from its own bit.
// - Source field: sys clock, sys/12, 5.33 us tick, 100 us pulse.
// - Clock fields at 7:6,5:4,3:2,1:0; low field clocks wide mode.
// - Same unit logic twice sharing one clock-select register.
// - Irq is high flag OR (low flag AND low irq enable).
// - Flags are cleared only by software writes.
// - All count sources are system-clock enables.
`timescale 1ns/100ps
`include "split_timer_defs.svh"

module timer_split_unit (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [4:0] wr_sel, // Register write strobes
  input wire split_timer_pkg::byte_t wdata, // Write data
  input wire logic cap_event, // Capture edge event pulse
  input wire split_timer_pkg::clk_field_t clk_lo, // Low half source
  input wire split_timer_pkg::clk_field_t clk_hi, // High half source
  count_src_if.dst src, // Count enables
  output split_timer_pkg::reg_view_t view, // Register readback
  output logic irq // Interrupt request
);
  import split_timer_pkg::*;

  unit_state_s s, n;
  logic split;
  logic [1:0] run;
  logic [1:0] capm;
  logic [1:0] en;
  logic [1:0] adv;
  logic [1:0] set_f;
  logic [15:0] wide_cnt;

  function automatic logic pick(clk_field_t f, logic d, logic t, logic p);
    case (f)
      `SRC_SYS: pick = 1'b1;
      `SRC_DIV12: pick = d;
      `SRC_TICK: pick = t;
      default: pick = p;
    endcase
  endfunction

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    n = s;
    set_f = 2'b00;
    split = s.ctrl[`CB_SPLIT];
    run = {s.ctrl[`CB_HRUN], s.ctrl[`CB_LRUN]};
    capm = {s.ctrl[`CB_HCAP], s.ctrl[`CB_LCAP]};
    en[0] = pick(clk_lo, src.div12, src.tick, src.pulse);
    en[1] = pick(clk_hi, src.div12, src.tick, src.pulse);
    adv = run & en;
    wide_cnt = {s.cnt[1], s.cnt[0]};
    if (!split)
    begin
      // Low half controls run, mode and source of the whole counter
      if (!capm[0])
      begin
        if (adv[0])
        begin
          if (s.cnt[0] == 8'hFF)
            set_f[0] = 1'b1;
          if (wide_cnt == 16'hFFFF)
          begin
            n.cnt = s.rld;
            set_f[1] = 1'b1;
          end
          else
            {n.cnt[1], n.cnt[0]} = 16'(wide_cnt + 16'h0001);
        end
      end
      else
      begin
        if (adv[0])
        begin
          {n.cnt[1], n.cnt[0]} = 16'(wide_cnt + 16'h0001);
          if (wide_cnt == 16'hFFFF)
            set_f[0] = 1'b1;
        end
        // Capture ignores run so a stopped counter can still be sampled
        if (cap_event)
        begin
          n.rld = s.cnt;
          set_f[1] = 1'b1;
        end
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!capm[i])
        begin
          if (adv[i])
          begin
            if (s.cnt[i] == 8'hFF)
            begin
              n.cnt[i] = s.rld[i];
              set_f[i] = 1'b1;
            end
            else
              n.cnt[i] = 8'(s.cnt[i] + 8'h01);
          end
        end
        else
        begin
          if (adv[i])
            n.cnt[i] = 8'(s.cnt[i] + 8'h01);
          if (cap_event)
          begin
            n.rld[i] = s.cnt[i];
            set_f[i] = 1'b1;
          end
        end
      end
    end
    // Software writes win over hardware updates of the data bytes
    if (wr_sel[`WS_CTRL])
      n.ctrl = wdata;
    if (wr_sel[`WS_RLD_L])
      n.rld[0] = wdata;
    if (wr_sel[`WS_RLD_H])
      n.rld[1] = wdata;
    if (wr_sel[`WS_CNT_L])
      n.cnt[0] = wdata;
    if (wr_sel[`WS_CNT_H])
      n.cnt[1] = wdata;
    // Set beats a clear written in the same cycle, no event is lost
    n.ctrl[`CB_HFLAG] = n.ctrl[`CB_HFLAG] | set_f[1];
    n.ctrl[`CB_LFLAG] = n.ctrl[`CB_LFLAG] | set_f[0];
    n.irq = n.ctrl[`CB_HFLAG] |
            (n.ctrl[`CB_LFLAG] & n.ctrl[`CB_LIRQ_EN]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s.ctrl <= `CTRL_RESET;
      s.cnt <= {`BYTE_RESET, `BYTE_RESET};
      s.rld <= {`BYTE_RESET, `BYTE_RESET};
      s.irq <= 1'b0;
    end
    else
      s <= n;
  end

  assign view = {s.cnt[1], s.cnt[0], s.rld[1], s.rld[0], s.ctrl};
  assign irq = s.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_wide_reload;
    @(posedge clk_sys) disable iff (!rst_n)
    (!split && !capm[0] && adv[0] && wide_cnt == 16'hFFFF &&
     wr_sel == 5'h00) |=> (s.cnt == $past(s.rld) && s.ctrl[`CB_HFLAG]);
  endproperty
  a_wide_reload: assert property (p_wide_reload)
    else $error("wide reload or high flag missed");

  property p_wide_low_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    (!split && !capm[0] && adv[0] && s.cnt[0] == 8'hFF &&
     wr_sel == 5'h00) |=> s.ctrl[`CB_LFLAG];
  endproperty
  a_wide_low_flag: assert property (p_wide_low_flag)
    else $error("low byte rollover flag missed");

  property p_wide_cap_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    (!split && capm[0] && adv[0] && wide_cnt == 16'hFFFF &&
     wr_sel == 5'h00) |=> (s.cnt == 16'h0000 && s.ctrl[`CB_LFLAG]);
  endproperty
  a_wide_cap_wrap: assert property (p_wide_cap_wrap)
    else $error("capture counter wrap wrong");

  property p_wide_capture;
    @(posedge clk_sys) disable iff (!rst_n)
    (!split && capm[0] && cap_event && wr_sel == 5'h00)
    |=> (s.rld == $past(s.cnt) && s.ctrl[`CB_HFLAG]);
  endproperty
  a_wide_capture: assert property (p_wide_capture)
    else $error("wide capture wrong");

  property p_split_timer_hi;
    @(posedge clk_sys) disable iff (!rst_n)
    (split && !capm[1] && adv[1] && s.cnt[1] == 8'hFF &&
     wr_sel == 5'h00)
    |=> (s.cnt[1] == $past(s.rld[1]) && s.ctrl[`CB_HFLAG]);
  endproperty
  a_split_timer_hi: assert property (p_split_timer_hi)
    else $error("split high reload wrong");

  property p_split_both_cap;
    @(posedge clk_sys) disable iff (!rst_n)
    (split && capm == 2'b11 && cap_event && wr_sel == 5'h00)
    |=> (s.ctrl[`CB_HFLAG] && s.ctrl[`CB_LFLAG]);
  endproperty
  a_split_both_cap: assert property (p_split_both_cap)
    else $error("shared capture missed a flag");

  property p_split_cap_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
    (split && capm[0] && !run[0] && cap_event && wr_sel == 5'h00)
    |=> (s.rld[0] == $past(s.cnt[0]) && $stable(s.cnt[0]) &&
         s.ctrl[`CB_LFLAG]);
  endproperty
  a_split_cap_stopped: assert property (p_split_cap_stopped)
    else $error("stopped low half capture wrong");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    ($fell(s.ctrl[`CB_HFLAG]) || $fell(s.ctrl[`CB_LFLAG]))
    |-> $past(wr_sel[`WS_CTRL]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag cleared without a write");

  property p_hold_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
    (!split && !run[0] && wr_sel == 5'h00) |=> $stable(s.cnt);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped)
    else $error("stopped counter moved");

  property p_irq_combine;
    @(posedge clk_sys) disable iff (!rst_n)
    s.irq == (s.ctrl[`CB_HFLAG] |
              (s.ctrl[`CB_LFLAG] & s.ctrl[`CB_LIRQ_EN]));
  endproperty
  a_irq_combine: assert property (p_irq_combine)
    else $error("irq does not match flags");

endmodule // timer_split_unit

module dual_split_timer_capture #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire split_timer_pkg::byte_t sfr_addr, // Register address
  input wire split_timer_pkg::byte_t sfr_wdata, // Write data
  input wire logic sfr_wr, // Write strobe
  output split_timer_pkg::byte_t sfr_rdata, // Registered read data
  input wire logic ext_event_zero, // Edge event, unit A capture
  input wire logic ext_event_one, // Edge event, unit B capture
  output logic irq_unit_a, // Unit A interrupt request
  output logic irq_unit_b // Unit B interrupt request
);
  import split_timer_pkg::*;

  localparam logic [1:0][7:0] BASES = {`BASE_UNIT_B, `BASE_UNIT_A};
  localparam logic [4:0][7:0] OFS = {`OFS_CNT_H, `OFS_CNT_L,
                                     `OFS_RLD_H, `OFS_RLD_L, `OFS_CTRL};

  top_state_s s, n;
  reg_view_t view [2];
  logic [1:0][4:0] wr_sel;
  logic [1:0] cap_ev;
  logic [1:0] irq_u;

  count_src_if src_bus ();

  count_source_gen #(
    .TICK_CYCLES(TICK_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_src (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .src(src_bus)
  );

  // ****************************************************
  // Timer units
  // ****************************************************
  // Events are only observed here, the edge detector keeps its own irq
  assign cap_ev = {ext_event_one, ext_event_zero};

  for (genvar u = 0; u < 2; u++) begin : g_unit
    for (genvar k = 0; k < 5; k++) begin : g_wr
      assign wr_sel[u][k] = sfr_wr &&
                            (sfr_addr == 8'(BASES[u] + OFS[k]));
    end
    timer_split_unit u_unit (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_sel(wr_sel[u]),
      .wdata(sfr_wdata),
      .cap_event(cap_ev[u]),
      .clk_lo(s.clksel[4*u +: 2]),
      .clk_hi(s.clksel[4*u+2 +: 2]),
      .src(src_bus),
      .view(view[u]),
      .irq(irq_u[u])
    );
  end

  // ****************************************************
  // Clock select and readback
  // ****************************************************
  always_comb
  begin
    n = s;
    if (sfr_wr && sfr_addr == `ADDR_CLKSEL)
      n.clksel = sfr_wdata;
    // Unmapped addresses read as zero
    n.rdata = 8'h00;
    if (sfr_addr == `ADDR_CLKSEL)
      n.rdata = s.clksel;
    for (int u = 0; u < 2; u++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (sfr_addr == 8'(BASES[u] + OFS[k]))
          n.rdata = view[u][k];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s.clksel <= `CLKSEL_RESET;
      s.rdata <= 8'h00;
    end
    else
      s <= n;
  end

  assign sfr_rdata = s.rdata;
  assign irq_unit_a = irq_u[0];
  assign irq_unit_b = irq_u[1];

endmodule // dual_split_timer_capture

// [sim/edge_event_model.sv]
`timescale 1ns/100ps

module edge_event_model (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [1:0] pin_in, // Pin levels, line one in bit 1
  input wire logic [3:0] edge_sel, // Per line: low bit rise, high bit fall
  output logic [1:0] evt // One-cycle edge events
);
  logic [1:0] pin_r;

  // ****************************************************
  // Edge detection, registered like the real detector
  // ****************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_r <= 2'h0;
      evt <= 2'h0;
    end
    else
    begin
      pin_r <= pin_in;
      for (int i = 0; i < 2; i++)
        evt[i] <= (edge_sel[2*i] & pin_in[i] & ~pin_r[i]) |
                  (edge_sel[2*i+1] & ~pin_in[i] & pin_r[i]);
    end
  end
endmodule // edge_event_model

// [sim/testbench.sv]
`timescale 1ns/100ps

module testbench;
  typedef struct packed {
    logic [7:0] d;
    logic ci;
    logic [1:0] irq;
  } note_s;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic rd_req = 1'b0;
  logic [1:0] pin_in = 2'h0;
  logic [3:0] edge_sel = 4'h9;
  logic [7:0] sfr_rdata;
  logic [1:0] evt;
  logic irq_unit_a;
  logic irq_unit_b;
  logic [31:0] rnd = 32'h1D20A00A;
  logic [15:0] rv;
  logic [15:0] cv;
  logic [7:0] rl;
  logic [7:0] rh;
  logic [7:0] hs;
  logic [1:0] sf;
  int n;
  int n_tab[4] = '{60, 5, 12, 3};
  int n_mismatch = 0;
  int checked = 0;
  note_s exp_q[$];
  note_s nt;

  // Short divider counts keep the run brief
  dual_split_timer_capture #(
    .TICK_CYCLES(5),
    .PULSE_CYCLES(20)
  ) dual_split_timer_capture_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rdata(sfr_rdata),
    .ext_event_zero(evt[0]),
    .ext_event_one(evt[1]),
    .irq_unit_a(irq_unit_a),
    .irq_unit_b(irq_unit_b)
  );

  edge_event_model edge_event_model_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .edge_sel(edge_sel),
    .evt(evt)
  );

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // All bus tasks start and end at a falling edge; one rising edge for wr and rd, k for idle
  // Strobes stay up into the next call, so each is set once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    rd_req = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic ci = 1'b0, input logic [1:0] iq = 2'h0);
    exp_q.push_back({d, ci, iq});
    sfr_addr = a;
    sfr_wr = 1'b0;
    rd_req = 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic idle(input int k);
    sfr_wr = 1'b0;
    rd_req = 1'b0;
    repeat (k) @(negedge clk_sys);
  endtask

  // ****************************************************
  // Monitor: read data lands one edge after the address
  // ****************************************************
  always @(posedge clk_sys)
  begin
    if (rd_req)
    begin
      #1;
      nt = exp_q.pop_front();
      check(sfr_rdata, nt.d);
      if (nt.ci)
        check({6'h00, irq_unit_b, irq_unit_a}, {6'h00, nt.irq});
    end
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(8'hC9, 8'h00);
    rd(8'hC8, 8'h00);
    rd(8'hD0, 8'h00);
    wr(8'hC0, 8'h5A);
    rd(8'hC0, 8'h00);
    rnd = lfsr(rnd);
    wr(8'hC9, rnd[7:0]);
    rd(8'hC9, rnd[7:0]);
    $display("test registers done");

    rnd = lfsr(rnd);
    rv = {rnd[15:8], 1'b0, rnd[6:0]};
    wr(8'hC9, 8'h00);
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hCA, rv[7:0]);
    wr(8'hCB, rv[15:8]);
    wr(8'hC8, 8'h21);
    idle(3);
    rd(8'hC8, 8'hE1, 1'b1, 2'h1);
    wr(8'hC8, 8'h00);
    rv = rv + 16'h0003;
    rd(8'hCC, rv[7:0]);
    rd(8'hCD, rv[15:8], 1'b1, 2'h0);
    $display("test wide timer done");

    // Unit B waits in split capture while unit A captures
    rnd = lfsr(rnd);
    cv = rnd[15:0];
    wr(8'hD0, 8'h1C);
    wr(8'hD4, rnd[23:16]);
    wr(8'hD5, rnd[31:24]);
    wr(8'hD2, 8'h00);
    wr(8'hCC, cv[7:0]);
    wr(8'hCD, cv[15:8]);
    wr(8'hC8, 8'h04);
    pin_in[0] = 1'b1;
    idle(4);
    rd(8'hCA, cv[7:0]);
    rd(8'hCB, cv[15:8]);
    rd(8'hCC, cv[7:0]);
    rd(8'hC8, 8'h84, 1'b1, 2'h1);
    rd(8'hD2, 8'h00);
    pin_in[1] = 1'b1;
    idle(4);
    rd(8'hD0, 8'h1C);
    pin_in[1] = 1'b0;
    idle(4);
    rd(8'hD2, rnd[23:16]);
    rd(8'hD3, rnd[31:24]);
    rd(8'hD0, 8'hDC, 1'b1, 2'h3);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h05);
    idle(2);
    rd(8'hC8, 8'h45, 1'b1, 2'h2);
    rd(8'hCD, 8'h00);
    $display("test capture done");

    // A 60-edge window holds a whole number of every source's periods
    for (int s = 0; s < 4; s++)
    begin
      rnd = lfsr(rnd);
      sf = 2'(s);
      n = n_tab[s];
      rl = {1'b0, rnd[6:0]};
      rh = rnd[15:8];
      hs = 8'(9'h100 - 9'(n));
      wr(8'hC9, {~sf, sf, sf, 2'h0});
      wr(8'hC8, 8'h10);
      wr(8'hCC, 8'hFE);
      wr(8'hCA, rl);
      wr(8'hCD, hs);
      wr(8'hCB, rh);
      wr(8'hD0, 8'h00);
      wr(8'hD4, 8'h00);
      wr(8'hD5, 8'h00);
      wr(8'hC8, 8'h33);
      wr(8'hD0, 8'h01);
      idle(10);
      rd(8'hC8, 8'h73, 1'b1, 2'h1);
      idle(47);
      wr(8'hC8, 8'h10);
      wr(8'hD0, 8'h00);
      rl = rl + 8'h3A;
      rd(8'hCC, rl);
      rd(8'hCD, rh);
      rd(8'hD4, 8'(n));
      rd(8'hD5, 8'h00);
      $display("test split source %0d done", s);
    end

    // Unit B split: low half captures freely, high half times
    wr(8'hC8, 8'h00);
    wr(8'hC9, 8'h00);
    wr(8'hD4, 8'hFE);
    wr(8'hD5, 8'hFE);
    wr(8'hD3, rl);
    wr(8'hD0, 8'h17);
    idle(3);
    rd(8'hD0, 8'h97, 1'b1, 2'h2);
    rd(8'hD4, 8'h02);
    rd(8'hD5, 8'(rl + 8'h03));
    $display("test split capture timer done");
    idle(2);
    finish_test();
  end
endmodule // testbench
